// ==== include/cra_pkg.sv ====
package cra_pkg;
	// ****************************************
	// Control port register addresses and soft reset key
	// ****************************************
	localparam logic [6:0] ADDR_ANALOGUE = 7'h04;
	localparam logic [6:0] ADDR_DIGITAL = 7'h05;
	localparam logic [6:0] ADDR_SAMPLING = 7'h08;
	localparam logic [6:0] ADDR_SOFT_RESET = 7'h0F;
	localparam logic [8:0] SOFT_RESET_KEY = 9'h000;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int ANA_SRC_BIT = 2;
	localparam int DIG_HPD_BIT = 0;
	localparam int DIG_HOLD_BIT = 4;
	localparam int SMP_RATE_LSB = 0;
	localparam int SMP_RATE_W = 6;
	localparam int SMP_CORE_BIT = 6;
	localparam int SMP_OUT_BIT = 7;
	// ****************************************
	// Field reset values
	// ****************************************
	localparam logic RST_SRC = 1'b0;
	localparam logic RST_HPD = 1'b0;
	localparam logic RST_HOLD = 1'b0;
	localparam logic RST_CORE_HALVE = 1'b0;
	localparam logic RST_OUT_HALVE = 1'b0;
	localparam logic [5:0] RST_RATE = 6'h00;
	// ****************************************
	// Rate decode and serial framing
	// ****************************************
	localparam logic [3:0] RATE_HIGH_CODE = 4'h7;
	localparam int FRAME_BITS_3W = 16;
	localparam int BYTE_BITS = 8;
	localparam logic [1:0] LAST_BYTE = 2'h2;
	typedef enum logic [1:0] {FILT_NORMAL, FILT_ALT, FILT_HIGH} cra_filt_t;
endpackage : cra_pkg

// ==== include/cra_hpf_if.sv ====
`timescale 1ns/1ps
interface cra_hpf_if #(parameter int W = 24);
	logic [W-1:0] x;
	logic x_valid;
	logic hp_en;
	logic hold;
	logic clr;
	logic [W-1:0] y;
	logic y_valid;
	modport core (output x, x_valid, hp_en, hold, clr, input y, y_valid);
	modport chan (input x, x_valid, hp_en, hold, clr, output y, y_valid);
endinterface : cra_hpf_if

// ==== rtl/cra_hpf_chan.sv ====
`timescale 1ns/1ps
module cra_hpf_chan
	import cra_pkg::*;
#(
	parameter int W = 24,
	parameter int SH = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	cra_hpf_if.chan hp
);
	generate
		if (W < 8 || SH < 1 || SH > 16) begin : g_bad
			$error("cra_hpf_chan: unsupported width or shift");
		end
	endgenerate

	// Offset estimate kept with SH fraction bits so small offsets still converge
	logic signed [W+SH-1:0] acc_r;
	logic signed [W+SH-1:0] acc_nxt;
	logic signed [W-1:0] off;
	logic signed [W:0] diff;
	logic signed [W-1:0] sat;
	logic [W-1:0] y_r;
	logic yv_r;

	assign off = acc_r[W+SH-1:SH];
	assign diff = {hp.x[W-1], hp.x} - {off[W-1], off};
	assign sat = (diff[W] != diff[W-1]) ? {diff[W], {(W-1){~diff[W]}}} : diff[W-1:0];

	always_comb begin
		acc_nxt = acc_r;
		if (hp.clr) begin
			acc_nxt = '0;
		end else if (hp.hp_en) begin
			if (hp.x_valid) begin
				acc_nxt = acc_r + {{(SH-1){diff[W]}}, diff};
			end
		end else if (!hp.hold) begin
			acc_nxt = '0;
		end
		// Disabled with hold set: estimate frozen until filter is enabled again or hold is cleared
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_r <= '0;
			y_r <= '0;
			yv_r <= 1'b0;
		end else begin
			acc_r <= acc_nxt;
			yv_r <= hp.x_valid;
			if (hp.x_valid) begin
				y_r <= sat;
			end
		end
	end

	assign hp.y = y_r;
	assign hp.y_valid = yv_r;
endmodule : cra_hpf_chan

// ==== rtl/cra_clock_reset_adc_ctrl.sv ====
`timescale 1ns/1ps
// Summary of operation
// - One bit routes both channels, mic or line
// - Digital path bit0 set disables high pass
// - Enabled filter tracks and subtracts dc offset
// - Hold bit keeps offset when disabled, else clears
// - Held offset frozen until filter re-enabled or hold bit cleared
// - Sample datapath is 24 bits wide
// - Filter type derived from configured sample rate
// - Writing zero to reset register resets device
// - Three-wire: reset on select rise, release on next serial clock rise
// - Two-wire: reset held during write acknowledge bit
// - Core runs at master rate or half
// - External reference clock needs no setting
// - Clock output is non-inverted copy of core
// - Clock output at core rate or half
// - Halved output changes only on master rising edges
// - Clock output held low during reset
// - Microphone bias off in standby
module cra_clock_reset_adc_ctrl
	import cra_pkg::*;
#(
	parameter int DATA_W = 24,
	parameter int HPF_SHIFT = 10,
	parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary two-wire device address
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic MODE_3WIRE,
	input wire logic SCLK,
	input wire logic SDIN_IN,
	output logic SDIN_OUT,
	output logic SDIN_OE,
	input wire logic CONTROL_CHIP_SELECT_B,
	input wire logic STANDBY,
	input wire logic [DATA_W-1:0] LINE_L,
	input wire logic [DATA_W-1:0] LINE_R,
	input wire logic [DATA_W-1:0] MIC,
	input wire logic SAMPLE_VALID,
	output logic [DATA_W-1:0] DOUT_L,
	output logic [DATA_W-1:0] DOUT_R,
	output logic DOUT_VALID,
	output logic ADC_SOURCE_SELECT,
	output logic [1:0] FILTER_TYPE,
	output logic CORE_CLOCK_EN,
	output logic BUFFERED_CLOCK_OUTPUT,
	output logic MICROPHONE_BIAS_OUTPUT,
	output logic SOFT_RESET_ACTIVE
);
	generate
		if (DATA_W != 24) begin : g_bad_w
			$error("cra_clock_reset_adc_ctrl: datapath must be 24 bits");
		end
	endgenerate

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_q1;
	logic rst_n;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// ****************************************
	// Control port pin sampling
	// ****************************************
	// Pins are synchronous to CLK; one stage of history gives the edges
	logic sclk_p;
	logic sdin_p;
	logic csb_p;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			sclk_p <= 1'b0;
			sdin_p <= 1'b1;
			csb_p <= 1'b1;
		end else begin
			sclk_p <= SCLK;
			sdin_p <= SDIN_IN;
			csb_p <= CONTROL_CHIP_SELECT_B;
		end
	end

	wire sclk_rise = SCLK & ~sclk_p;
	wire sclk_fall = ~SCLK & sclk_p;
	wire csb_rise = CONTROL_CHIP_SELECT_B & ~csb_p;
	wire tw_start = ~MODE_3WIRE & SCLK & sclk_p & sdin_p & ~SDIN_IN;
	wire tw_stop = ~MODE_3WIRE & SCLK & sclk_p & ~sdin_p & SDIN_IN;

	// ****************************************
	// Two-wire framing
	// ****************************************
	typedef enum logic [1:0] {TW_IDLE, TW_BITS, TW_ACK} cra_tw_t;

	cra_tw_t tw_r;
	cra_tw_t tw_nxt;
	logic [3:0] bcnt_r;
	logic [3:0] bcnt_nxt;
	logic [1:0] byte_r;
	logic [1:0] byte_nxt;
	logic [15:0] sr_r;
	logic tw_ack;
	logic tw_wr;

	wire byte_done = (tw_r == TW_BITS) && sclk_fall && (bcnt_r == 4'(BYTE_BITS));
	wire addr_match = (sr_r[7:1] == DEV_ADDR) && !sr_r[0];
	wire tw_shift = (tw_r == TW_BITS) && sclk_rise && (bcnt_r != 4'(BYTE_BITS));
	wire tw_shift_ok = tw_shift;
	wire tw_3_shift = MODE_3WIRE && !CONTROL_CHIP_SELECT_B && sclk_rise;

	always_comb begin
		tw_nxt = tw_r;
		bcnt_nxt = bcnt_r;
		byte_nxt = byte_r;
		tw_ack = 1'b0;
		tw_wr = 1'b0;
		if (tw_start) begin
			tw_nxt = TW_BITS;
			bcnt_nxt = 4'h0;
			byte_nxt = 2'h0;
		end else if (tw_stop || MODE_3WIRE) begin
			tw_nxt = TW_IDLE;
		end else begin
			unique case (tw_r)
				TW_IDLE: begin
					tw_nxt = TW_IDLE;
				end
				TW_BITS: begin
					if (tw_shift_ok) begin
						bcnt_nxt = bcnt_r + 4'h1;
					end
					if (byte_done) begin
						tw_ack = (byte_r != 2'h0) || addr_match;
						tw_wr = byte_r == LAST_BYTE;
						tw_nxt = tw_ack ? TW_ACK : TW_IDLE;
					end
				end
				TW_ACK: begin
					if (sclk_fall) begin
						bcnt_nxt = 4'h0;
						byte_nxt = byte_r + 2'h1;
						// Further bytes after the data word are ignored until a new start
						tw_nxt = (byte_r == LAST_BYTE) ? TW_IDLE : TW_BITS;
					end
				end
				default: begin
					tw_nxt = TW_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			tw_r <= TW_IDLE;
			bcnt_r <= 4'h0;
			byte_r <= 2'h0;
		end else begin
			tw_r <= tw_nxt;
			bcnt_r <= bcnt_nxt;
			byte_r <= byte_nxt;
		end
	end

	// One shift register serves both modes; two-wire bytes land as {addr byte, data byte}
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			sr_r <= 16'h0000;
		end else if (tw_3_shift || tw_shift_ok) begin
			sr_r <= {sr_r[14:0], SDIN_IN};
		end
	end

	// ****************************************
	// Write decode and soft reset
	// ****************************************
	wire wr_stb = MODE_3WIRE ? csb_rise : tw_wr;
	wire [6:0] wr_addr = sr_r[15:9];
	wire [8:0] wr_data = sr_r[8:0];
	wire rst_wr = wr_stb && wr_addr == ADDR_SOFT_RESET && wr_data == SOFT_RESET_KEY;
	wire cfg_wr = wr_stb && !rst_wr;
	wire sw_release = MODE_3WIRE ? sclk_rise : (tw_r == TW_ACK && sclk_fall);

	logic swrst_r;
	logic swrst_nxt;
	logic sda_oe_r;
	logic sda_out_r;

	// Setting wins over release when both land in the same cycle
	assign swrst_nxt = rst_wr ? 1'b1 : (sw_release ? 1'b0 : swrst_r);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			swrst_r <= 1'b0;
			sda_oe_r <= 1'b0;
			sda_out_r <= 1'b0;
		end else begin
			swrst_r <= swrst_nxt;
			// Open drain: only ever pulls low during the acknowledge bit
			sda_oe_r <= (tw_nxt == TW_ACK);
			sda_out_r <= 1'b0;
		end
	end

	// ****************************************
	// Control fields
	// ****************************************
	logic src_mic_r;
	logic hpd_r;
	logic hold_r;
	logic core_halve_r;
	logic out_halve_r;
	logic [SMP_RATE_W-1:0] rate_r;

	wire wr_ana = cfg_wr && wr_addr == ADDR_ANALOGUE;
	wire wr_dig = cfg_wr && wr_addr == ADDR_DIGITAL;
	wire wr_smp = cfg_wr && wr_addr == ADDR_SAMPLING;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			src_mic_r <= RST_SRC;
			hpd_r <= RST_HPD;
			hold_r <= RST_HOLD;
			core_halve_r <= RST_CORE_HALVE;
			out_halve_r <= RST_OUT_HALVE;
			rate_r <= RST_RATE;
		end else if (swrst_r) begin
			src_mic_r <= RST_SRC;
			hpd_r <= RST_HPD;
			hold_r <= RST_HOLD;
			core_halve_r <= RST_CORE_HALVE;
			out_halve_r <= RST_OUT_HALVE;
			rate_r <= RST_RATE;
		end else begin
			if (wr_ana) begin
				src_mic_r <= wr_data[ANA_SRC_BIT];
			end
			if (wr_dig) begin
				hpd_r <= wr_data[DIG_HPD_BIT];
				hold_r <= wr_data[DIG_HOLD_BIT];
			end
			if (wr_smp) begin
				core_halve_r <= wr_data[SMP_CORE_BIT];
				out_halve_r <= wr_data[SMP_OUT_BIT];
				rate_r <= wr_data[SMP_RATE_LSB +: SMP_RATE_W];
			end
		end
	end

	// ****************************************
	// Clock enables and clock output
	// ****************************************
	// CLK is the master clock whatever drives the input pin
	logic core_div_r;
	logic out_div_r;
	logic core_en_r;
	logic buffered_clock_output_r;

	wire core_tick = core_halve_r ? core_div_r : 1'b1;
	wire out_tick = core_tick && (!out_halve_r || out_div_r);
	wire in_reset = swrst_r || swrst_nxt;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			core_div_r <= 1'b0;
			out_div_r <= 1'b0;
			core_en_r <= 1'b0;
			buffered_clock_output_r <= 1'b0;
		end else if (in_reset) begin
			core_div_r <= 1'b0;
			out_div_r <= 1'b0;
			core_en_r <= 1'b0;
			buffered_clock_output_r <= 1'b0;
		end else begin
			core_div_r <= ~core_div_r;
			core_en_r <= core_tick;
			if (core_tick) begin
				out_div_r <= ~out_div_r;
			end
			// Output is a flop off CLK, so it only ever moves on master rising edges
			if (out_tick) begin
				buffered_clock_output_r <= ~buffered_clock_output_r;
			end
		end
	end

	// ****************************************
	// Microphone bias and filter type
	// ****************************************
	function automatic logic [1:0] filt_of(input logic [SMP_RATE_W-1:0] r);
		if (r[5:2] == RATE_HIGH_CODE) begin
			filt_of = FILT_HIGH;
		end else if (r[0]) begin
			filt_of = FILT_ALT;
		end else begin
			filt_of = FILT_NORMAL;
		end
	endfunction : filt_of

	logic [1:0] filt_r;
	logic mic_bias_r;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			filt_r <= FILT_NORMAL;
			mic_bias_r <= 1'b0;
		end else begin
			filt_r <= filt_of(rate_r);
			mic_bias_r <= !STANDBY;
		end
	end

	// ****************************************
	// Offset removal channels
	// ****************************************
	cra_hpf_if #(.W(DATA_W)) hpf_l ();
	cra_hpf_if #(.W(DATA_W)) hpf_r ();

	// Mono microphone feeds both channels; the pair never splits
	assign hpf_l.x = src_mic_r ? MIC : LINE_L;
	assign hpf_r.x = src_mic_r ? MIC : LINE_R;
	assign hpf_l.x_valid = SAMPLE_VALID;
	assign hpf_r.x_valid = SAMPLE_VALID;
	assign hpf_l.hp_en = !hpd_r;
	assign hpf_r.hp_en = !hpd_r;
	assign hpf_l.hold = hold_r;
	assign hpf_r.hold = hold_r;
	assign hpf_l.clr = swrst_r;
	assign hpf_r.clr = swrst_r;

	cra_hpf_chan #(.W(DATA_W), .SH(HPF_SHIFT)) u_hpf_l (
		.clk(CLK),
		.rst_n(rst_n),
		.hp(hpf_l.chan)
	);

	cra_hpf_chan #(.W(DATA_W), .SH(HPF_SHIFT)) u_hpf_r (
		.clk(CLK),
		.rst_n(rst_n),
		.hp(hpf_r.chan)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign DOUT_L = hpf_l.y;
	assign DOUT_R = hpf_r.y;
	assign DOUT_VALID = hpf_l.y_valid;
	assign ADC_SOURCE_SELECT = src_mic_r;
	assign FILTER_TYPE = filt_r;
	assign CORE_CLOCK_EN = core_en_r;
	assign BUFFERED_CLOCK_OUTPUT = buffered_clock_output_r;
	assign MICROPHONE_BIAS_OUTPUT = mic_bias_r;
	assign SOFT_RESET_ACTIVE = swrst_r;
	assign SDIN_OUT = sda_out_r;
	assign SDIN_OE = sda_oe_r;
endmodule : cra_clock_reset_adc_ctrl

// ==== bench/cra_props.sv ====
`timescale 1ns/1ps
module cra_props (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic MODE_3WIRE,
	input wire logic SCLK,
	input wire logic CONTROL_CHIP_SELECT_B,
	input wire logic STANDBY,
	input wire logic SAMPLE_VALID,
	input wire logic DOUT_VALID,
	input wire logic ADC_SOURCE_SELECT,
	input wire logic [1:0] FILTER_TYPE,
	input wire logic CORE_CLOCK_EN,
	input wire logic BUFFERED_CLOCK_OUTPUT,
	input wire logic MICROPHONE_BIAS_OUTPUT,
	input wire logic SOFT_RESET_ACTIVE,
	input wire logic SDIN_OUT,
	input wire logic SDIN_OE
);
	// ****
	// Settle window: the design runs from a synchronised reset copy
	// ****
	logic [2:0] up_r;
	logic [2:0] st_r;
	logic rdy;
	assign rdy = up_r == 3'h7;
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			up_r <= 3'h0;
		end else if (!rdy) begin
			up_r <= up_r + 3'h1;
		end
	end
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_r <= 3'h0;
		end else if (!rdy || SOFT_RESET_ACTIVE || $changed(BUFFERED_CLOCK_OUTPUT)) begin
			st_r <= 3'h0;
		end else if (st_r != 3'h7) begin
			st_r <= st_r + 3'h1;
		end
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B || !rdy);
	property p_bias; STANDBY |=> !MICROPHONE_BIAS_OUTPUT; endproperty
	a_bias: assert property (p_bias) else $error("bias on in standby");
	property p_dout; DOUT_VALID == $past(SAMPLE_VALID); endproperty
	a_dout: assert property (p_dout) else $error("sample valid lost");
	property p_low; SOFT_RESET_ACTIVE |-> !BUFFERED_CLOCK_OUTPUT && !CORE_CLOCK_EN; endproperty
	a_low: assert property (p_low) else $error("clock out during reset");
	property p_set;
		$rose(SOFT_RESET_ACTIVE) && MODE_3WIRE |-> CONTROL_CHIP_SELECT_B && !$past(CONTROL_CHIP_SELECT_B, 3);
	endproperty
	a_set: assert property (p_set) else $error("reset not at select rise");
	property p_rel; SOFT_RESET_ACTIVE && MODE_3WIRE && $rose(SCLK) |-> ##[1:3] !SOFT_RESET_ACTIVE; endproperty
	a_rel: assert property (p_rel) else $error("reset not released");
	property p_stay; SOFT_RESET_ACTIVE && MODE_3WIRE && !SCLK |=> SOFT_RESET_ACTIVE; endproperty
	a_stay: assert property (p_stay) else $error("reset dropped early");
	property p_def; $fell(SOFT_RESET_ACTIVE) |-> !ADC_SOURCE_SELECT && FILTER_TYPE == 2'h0; endproperty
	a_def: assert property (p_def) else $error("fields not default");
	property p_ft;
		($changed(FILTER_TYPE) || $changed(ADC_SOURCE_SELECT)) && MODE_3WIRE |->
			CONTROL_CHIP_SELECT_B && $past(CONTROL_CHIP_SELECT_B);
	endproperty
	a_ft: assert property (p_ft) else $error("field moved mid frame");
	property p_tick;
		!CORE_CLOCK_EN && !SOFT_RESET_ACTIVE && !$past(SOFT_RESET_ACTIVE) |=> CORE_CLOCK_EN || SOFT_RESET_ACTIVE;
	endproperty
	a_tick: assert property (p_tick) else $error("core tick gap");
	property p_out; !SOFT_RESET_ACTIVE |-> st_r <= 3'h4; endproperty
	a_out: assert property (p_out) else $error("clock out stalled");
	property p_hold2; SOFT_RESET_ACTIVE && !MODE_3WIRE && SCLK |=> SOFT_RESET_ACTIVE; endproperty
	a_hold2: assert property (p_hold2) else $error("reset dropped inside acknowledge");
	property p_ack; SDIN_OE |-> !SDIN_OUT && !MODE_3WIRE; endproperty
	a_ack: assert property (p_ack) else $error("data line driven wrongly");
endmodule : cra_props
bind cra_clock_reset_adc_ctrl cra_props i_cra_props (.CLK(CLK), .RST_B(RST_B), .MODE_3WIRE(MODE_3WIRE),
	.SCLK(SCLK), .CONTROL_CHIP_SELECT_B(CONTROL_CHIP_SELECT_B), .STANDBY(STANDBY), .SAMPLE_VALID(SAMPLE_VALID),
	.DOUT_VALID(DOUT_VALID), .ADC_SOURCE_SELECT(ADC_SOURCE_SELECT), .FILTER_TYPE(FILTER_TYPE),
	.CORE_CLOCK_EN(CORE_CLOCK_EN), .BUFFERED_CLOCK_OUTPUT(BUFFERED_CLOCK_OUTPUT),
	.MICROPHONE_BIAS_OUTPUT(MICROPHONE_BIAS_OUTPUT), .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE),
	.SDIN_OUT(SDIN_OUT), .SDIN_OE(SDIN_OE));

// ==== bench/cra_host.sv ====
`timescale 1ns/1ps
module cra_host (
	input wire logic clk,
	input wire logic sda,
	output logic sclk,
	output logic sdin,
	output logic control_chip_select_b
);
	initial begin
		sclk = 1'b0;
		sdin = 1'b0;
		control_chip_select_b = 1'b1;
	end
	// Whole 16-bit frames only; a reset is just a frame of zero data
	task automatic write(input logic [6:0] a, input logic [8:0] d);
		logic [15:0] w;
		w = {a, d};
		@(negedge clk);
		control_chip_select_b = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdin = w[i];
			repeat (2) @(negedge clk);
			sclk = 1'b1;
			repeat (2) @(negedge clk);
			sclk = 1'b0;
		end
		repeat (2) @(negedge clk);
		control_chip_select_b = 1'b1;
		// Released line must not look like held data
		sdin = ~sdin;
		repeat (4) @(negedge clk);
	endtask : write
	// Two-wire write of three bytes; sdin high releases the line, nak counts missing acknowledges
	task automatic write2(input logic [23:0] w, output int nak);
		nak = 0;
		sdin = 1'b1;
		repeat (2) @(negedge clk);
		sclk = 1'b1;
		repeat (2) @(negedge clk);
		sdin = 1'b0;
		repeat (2) @(negedge clk);
		sclk = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			repeat (2) @(negedge clk);
			sdin = w[i];
			repeat (2) @(negedge clk);
			sclk = 1'b1;
			repeat (2) @(negedge clk);
			sclk = 1'b0;
			if (i % 8 == 0) begin
				repeat (2) @(negedge clk);
				sdin = 1'b1;
				repeat (2) @(negedge clk);
				sclk = 1'b1;
				repeat (2) @(negedge clk);
				nak += (sda !== 1'b0);
				sclk = 1'b0;
			end
		end
		repeat (2) @(negedge clk);
		sdin = 1'b0;
		repeat (2) @(negedge clk);
		sclk = 1'b1;
		repeat (2) @(negedge clk);
		sdin = 1'b1;
		repeat (4) @(negedge clk);
	endtask : write2
endmodule : cra_host

// ==== bench/test_clock_reset_adc_path_ctrl.sv ====
`timescale 1ns/1ps
module test_clock_reset_adc_path_ctrl;
	import cra_pkg::*;
	localparam int SH = 2;
	localparam logic [6:0] TWA = 7'h2A;
	logic CLK = 1'b0;
	logic RST_B = 1'b0;
	logic STANDBY = 1'b0;
	logic SAMPLE_VALID = 1'b0;
	logic [23:0] LINE_L = 24'h0, LINE_R = 24'h0, MIC = 24'h0;
	logic SCLK, SDIN_IN, CONTROL_CHIP_SELECT, DOUT_VALID, ASEL, CORE_CLOCK_EN, BCO, MBO, SRA, SDA_H, SDA_OE, SDA_OUT;
	logic M3 = 1'b1;
	logic [1:0] FT;
	logic [23:0] DOUT_L, DOUT_R;
	int n_fail = 0, num_checks = 0, cyc = 0, acc, off, y, t, e, nak, srh = 0;
	always #5 CLK = ~CLK;
	// Pull-up on the data line; host and device may each pull it low
	assign SDIN_IN = SDA_H && !(SDA_OE && !SDA_OUT);
	// Cycles spent in soft reset, counted mid-cycle where the flag is settled
	always @(negedge CLK) srh += (SRA === 1'b1);
	cra_host i_cra_host (.clk(CLK), .sda(SDIN_IN), .sclk(SCLK), .sdin(SDA_H), .control_chip_select_b(CONTROL_CHIP_SELECT));
	cra_clock_reset_adc_ctrl #(.DATA_W(24), .HPF_SHIFT(SH), .DEV_ADDR(TWA)) i_cra_clock_reset_adc_ctrl (.CLK(CLK),
		.RST_B(RST_B), .MODE_3WIRE(M3), .SCLK(SCLK), .SDIN_IN(SDIN_IN), .SDIN_OUT(SDA_OUT), .SDIN_OE(SDA_OE),
		.CONTROL_CHIP_SELECT_B(CONTROL_CHIP_SELECT),
		.STANDBY(STANDBY), .LINE_L(LINE_L), .LINE_R(LINE_R), .MIC(MIC), .SAMPLE_VALID(SAMPLE_VALID),
		.DOUT_L(DOUT_L), .DOUT_R(DOUT_R), .DOUT_VALID(DOUT_VALID), .ADC_SOURCE_SELECT(ASEL), .FILTER_TYPE(FT),
		.CORE_CLOCK_EN(CORE_CLOCK_EN), .BUFFERED_CLOCK_OUTPUT(BCO), .MICROPHONE_BIAS_OUTPUT(MBO),
		.SOFT_RESET_ACTIVE(SRA));
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic smp(input int l, input int r, input int m);
		@(negedge CLK);
		LINE_L = 24'(l);
		LINE_R = 24'(r);
		MIC = 24'(m);
		SAMPLE_VALID = 1'b1;
		@(negedge CLK);
		SAMPLE_VALID = 1'b0;
		chk(DOUT_VALID, 1'b1);
	endtask : smp
	task automatic meas();
		logic p;
		t = 0;
		e = 0;
		p = BCO;
		repeat (16) begin
			@(negedge CLK);
			t += (CORE_CLOCK_EN === 1'b1);
			e += (BCO !== p);
			p = BCO;
		end
	endtask : meas
	task automatic end_sim();
		if (n_fail == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			end_sim();
		end
	end
	// ****
	// Main sequence
	// ****
	initial begin
		repeat (8) @(negedge CLK);
		RST_B = 1'b1;
		repeat (4) @(negedge CLK);
		for (int k = 0; k < 4; k++) begin
			i_cra_host.write(ADDR_SAMPLING, {1'b0, k[1], k[0], 6'h00});
			meas();
			chk(24'(t), 24'(16 >> k[0]));
			chk(24'(e), 24'((16 >> k[0]) >> k[1]));
		end
		i_cra_host.write(ADDR_SAMPLING, 9'h01D);
		chk(FT, 2'h2);
		i_cra_host.write(ADDR_SAMPLING, 9'h001);
		chk(FT, 2'h1);
		i_cra_host.write(ADDR_SAMPLING, 9'h000);
		chk(FT, 2'h0);
		i_cra_host.write(ADDR_DIGITAL, 9'h001);
		i_cra_host.write(ADDR_ANALOGUE, 9'h004);
		chk(ASEL, 1'b1);
		smp(1, 2, 5);
		chk(DOUT_L, 24'h5);
		chk(DOUT_R, 24'h5);
		i_cra_host.write(ADDR_ANALOGUE, 9'h000);
		smp(1, 2, 5);
		chk(DOUT_L, 24'h1);
		chk(DOUT_R, 24'h2);
		i_cra_host.write(ADDR_DIGITAL, 9'h000);
		acc = 0;
		repeat (6) begin
			off = acc >>> SH;
			y = 1000 - off;
			smp(1000, 1000, 0);
			chk(DOUT_L, 24'(y));
			acc += y;
		end
		i_cra_host.write(ADDR_DIGITAL, 9'h011);
		off = acc >>> SH;
		repeat (2) begin
			smp(3000, 3000, 0);
			chk(DOUT_R, 24'(3000 - off));
		end
		i_cra_host.write(ADDR_DIGITAL, 9'h001);
		smp(3000, 3000, 0);
		chk(DOUT_L, 24'd3000);
		STANDBY = 1'b1;
		repeat (2) @(negedge CLK);
		chk(MBO, 1'b0);
		STANDBY = 1'b0;
		repeat (2) @(negedge CLK);
		chk(MBO, 1'b1);
		i_cra_host.write(ADDR_SAMPLING, 9'h0C1);
		i_cra_host.write(ADDR_ANALOGUE, 9'h004);
		i_cra_host.write(ADDR_SOFT_RESET, SOFT_RESET_KEY);
		chk(SRA, 1'b1);
		chk(BCO, 1'b0);
		// Unmapped write: its first serial clock rise ends the soft reset
		i_cra_host.write(7'h03, 9'h1FF);
		chk(SRA, 1'b0);
		chk(ASEL, 1'b0);
		chk(FT, 2'h0);
		meas();
		chk(24'(e), 24'd16);
		smp(77, 77, 0);
		chk(DOUT_L, 24'd77);
		// Two-wire port: acknowledge, refused address, soft reset over one acknowledge bit
		M3 = 1'b0;
		i_cra_host.write2({TWA, 1'b0, ADDR_ANALOGUE, 9'h004}, nak);
		chk(24'(nak), 24'd0);
		chk(ASEL, 1'b1);
		i_cra_host.write2({~TWA, 1'b0, ADDR_ANALOGUE, 9'h000}, nak);
		chk(24'(nak), 24'd3);
		chk(ASEL, 1'b1);
		t = srh;
		i_cra_host.write2({TWA, 1'b0, ADDR_SOFT_RESET, SOFT_RESET_KEY}, nak);
		chk(24'(nak), 24'd0);
		chk(24'(srh - t), 24'd6);
		chk(SRA, 1'b0);
		chk(ASEL, 1'b0);
		end_sim();
	end
endmodule : test_clock_reset_adc_path_ctrl
